// File: src/t1dl_pkg.sv
package t1dl_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_BOM_CTRL  = 8'h81;
    localparam logic [7:0] IDX_BOM_EVENT = 8'h82;
    localparam logic [7:0] IDX_BOM_CODE  = 8'h83;
    localparam logic [7:0] IDX_TX_EN     = 8'h84;
    localparam logic [7:0] IDX_TX2_MAP   = 8'h86;
    localparam logic [7:0] IDX_TX3_MAP   = 8'h87;
    localparam logic [7:0] IDX_TX2_MASK  = 8'h89;
    localparam logic [7:0] IDX_TX3_MASK  = 8'h8A;
    localparam logic [7:0] IDX_RX_EN     = 8'h8B;
    localparam logic [7:0] IDX_RX2_MAP   = 8'h8D;
    localparam logic [7:0] IDX_RX3_MAP   = 8'h8E;
    localparam logic [7:0] IDX_RX2_MASK  = 8'h90;
    localparam logic [7:0] IDX_RX3_MASK  = 8'h91;

    // slot units in order: tx2, tx3, rx2, rx3
    localparam int         UNITS = 4;
    localparam logic [7:0] MAP_IDX  [UNITS] = '{8'h86, 8'h87, 8'h8D, 8'h8E};
    localparam logic [7:0] MASK_IDX [UNITS] = '{8'h89, 8'h8A, 8'h90, 8'h91};

    // field positions
    localparam int VALSEL_BIT = 1;
    localparam int IRQEN_BIT  = 0;
    localparam int FLAG_BIT   = 0;
    localparam int EVEN_BIT   = 6;
    localparam int ODD_BIT    = 5;
    localparam int LINK1_BIT  = 0;
    localparam int LINK2_BIT  = 1;
    localparam int LINK3_BIT  = 2;

    // values after reset
    localparam logic [5:0] RST_CODE = 6'h3F;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [2:0] RST_EN   = 3'h0;
    localparam logic [6:0] RST_MAP  = 7'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    localparam logic [4:0] LAST_SLOT = 5'h17;
    localparam logic [2:0] LAST_LANE = 3'h7;

    // validation windows: receptions kept and agreements needed
    localparam int         HIST_DEPTH = 10;
    localparam logic [3:0] LONG_WIN   = 4'hA;
    localparam logic [3:0] LONG_THR   = 4'h8;
    localparam logic [3:0] SHORT_WIN  = 4'h5;
    localparam logic [3:0] SHORT_THR  = 4'h4;

endpackage : t1dl_pkg

// File: src/bom_validator.sv
`timescale 1ns/10ps
module bom_validator (
    input  logic       clk,
    input  logic       rstn,
    input  logic       rx_valid,
    input  logic       rx_match,
    input  logic [5:0] rx_code,
    input  logic       esf,
    input  logic       validation_select,
    output logic       declare_o,
    output logic [5:0] code_o
);
    logic [5:0] hist_code_reg [t1dl_pkg::HIST_DEPTH];
    logic       hist_ok_reg   [t1dl_pkg::HIST_DEPTH];
    logic [5:0] last_reg;
    logic       decl_reg;
    logic [5:0] out_reg;
    logic       short_win;
    logic [3:0] win;
    logic [3:0] thr;
    logic [3:0] cnt;
    logic [t1dl_pkg::HIST_DEPTH-1:0] agree;
    logic       decl_next;

    // outside ESF the select is ignored and the long window holds [RULE3]
    assign short_win = esf & validation_select;
    assign win = short_win ? t1dl_pkg::SHORT_WIN : t1dl_pkg::LONG_WIN;
    assign thr = short_win ? t1dl_pkg::SHORT_THR : t1dl_pkg::LONG_THR;

    // slot 0 is the reception arriving now, the rest are older ones
    genvar g;
    generate
        for (g = 0; g < t1dl_pkg::HIST_DEPTH; g++) begin : g_agree
            if (g == 0) begin : g_new
                assign agree[g] = rx_match;
            end else begin : g_old
                assign agree[g] = rx_match & hist_ok_reg[g-1]
                                & (hist_code_reg[g-1] == rx_code);
            end
        end
    endgenerate

    always_comb begin
        cnt = 4'h0;
        for (int i = 0; i < t1dl_pkg::HIST_DEPTH; i++) begin
            if (4'(i) < win) begin
                cnt = cnt + {3'h0, agree[i]};
            end
        end
    end

    // 8 of 10 or 4 of 5, and a new code only [RULE1] [RULE2]
    assign decl_next = rx_valid & rx_match & (cnt >= thr)
                     & (rx_code != last_reg);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < t1dl_pkg::HIST_DEPTH; i++) begin
                hist_code_reg[i] <= 6'h00;
                hist_ok_reg[i]   <= 1'b0;
            end
        end else if (rx_valid) begin
            hist_code_reg[0] <= rx_code;
            hist_ok_reg[0]   <= rx_match;
            for (int i = 1; i < t1dl_pkg::HIST_DEPTH; i++) begin
                hist_code_reg[i] <= hist_code_reg[i-1];
                hist_ok_reg[i]   <= hist_ok_reg[i-1];
            end
        end
    end

    // idle all-ones starts as the previous code so idle cannot declare until another code has been declared
    always_ff @(posedge clk) begin
        if (!rstn) begin
            last_reg <= t1dl_pkg::RST_CODE;
            decl_reg <= 1'b0;
            out_reg  <= t1dl_pkg::RST_CODE;
        end else begin
            decl_reg <= decl_next;
            if (decl_next) begin
                last_reg <= rx_code;
                out_reg  <= rx_code;
            end
        end
    end

    assign declare_o = decl_reg;
    assign code_o    = out_reg;

    property p_enough_agree;
        @(posedge clk) disable iff (!rstn)
        declare_o |-> ($past(cnt) >= $past(thr)) && $past(rx_match);
    endproperty
    a_enough_agree: assert property (p_enough_agree) // [RULE1] [RULE2]
        else $error("message declared without enough agreement");

    property p_new_code;
        @(posedge clk) disable iff (!rstn)
        declare_o |-> code_o != $past(last_reg);
    endproperty
    a_new_code: assert property (p_new_code) // [RULE1]
        else $error("message declared equal to previous one");

    property p_long_outside_esf;
        @(posedge clk) disable iff (!rstn)
        !esf |-> (thr == 4'h8) && (win == 4'hA);
    endproperty
    a_long_outside_esf: assert property (p_long_outside_esf) // [RULE3]
        else $error("short window used outside ESF");

endmodule : bom_validator

// File: src/t1_data_link_control.sv
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
// Function
// RULE1: ESF default: 8 of 10 agree, new code
// RULE2: select set: 4 of 5 agree, new code
// RULE3: validation select counts only in ESF
// RULE4: irq follows flag while enable set
// RULE5: flag sets on code update, write-one clears
// RULE6: declared code loaded, field bit5 is LSB
// RULE7: senders 2,3 gated by their enable bits
// RULE8: sender 1 enable only in ESF/DM
// RULE9: receivers 2,3 gated by their enable bits
// RULE10: receiver 1 enable only in ESF/DM
// RULE11: senders insert in selected even/odd frames
// RULE12: sender slot binary, 0 is channel 1
// RULE13: sender inserts only at selected lanes
// RULE14: lane select bit 7 is first bit
// RULE15: receivers extract in selected even/odd frames
// RULE16: receiver slot binary, 0 is channel 1
// RULE17: receiver extracts at selected lanes, 7 first
// RULE18: slot above 23 selects no channel
module t1_data_link_control (
    input  logic        CLK,
    input  logic        RSTN,
    input  logic        WB_CYC_I,
    input  logic        WB_STB_I,
    input  logic        WB_WE_I,
    input  logic [9:0]  WB_ADR_I,
    input  logic [3:0]  WB_SEL_I,
    input  logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic        WB_ACK_O,
    input  logic        ESF_FORMAT,
    input  logic        DM_FORMAT,
    input  logic        BOM_RX_VALID,
    input  logic        BOM_RX_MATCH,
    input  logic [5:0]  BOM_RX_CODE,
    output logic        MSG_IRQ,
    output logic [2:0]  TX_LINK_EN,
    output logic [2:0]  RX_LINK_EN,
    input  logic        LINE_BIT_VALID,
    input  logic [4:0]  LINE_CHANNEL,
    input  logic [2:0]  LINE_BIT_INDEX,
    input  logic        LINE_FRAME_ODD,
    input  logic        TX_LINE_BIT_I,
    input  logic        TX2_HDLC_BIT,
    input  logic        TX3_HDLC_BIT,
    input  logic        RX_LINE_BIT,
    output logic        TX_LINE_BIT_O,
    output logic        TX_LINE_VALID_O,
    output logic        TX2_BIT_TAKEN,
    output logic        TX3_BIT_TAKEN,
    output logic        RX2_BIT_VALID,
    output logic        RX3_BIT_VALID,
    output logic        RX_HDLC_BIT
);
    logic [1:0]  ctrl_reg;
    logic        flag_reg;
    logic        flag_next;
    logic [5:0]  code_reg;
    logic [2:0]  txen_reg;
    logic [2:0]  rxen_reg;
    logic [6:0]  map_reg  [t1dl_pkg::UNITS];
    logic [7:0]  mask_reg [t1dl_pkg::UNITS];
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_reg;
    logic [7:0]  rd_byte;
    logic [7:0]  idx;
    logic        wr_take;
    logic        flag_clr;
    logic        decl;
    logic [5:0]  decl_code;
    logic        fmt_dl;
    logic [2:0]  lane;
    logic [t1dl_pkg::UNITS-1:0] unit_en;
    logic [t1dl_pkg::UNITS-1:0] hit;
    logic [2:0]  tx_en_reg;
    logic [2:0]  rx_en_reg;
    logic        tx_bit_reg;
    logic        tx_val_reg;
    logic        tx2_take_reg;
    logic        tx3_take_reg;
    logic        rx2_val_reg;
    logic        rx3_val_reg;
    logic        rx_bit_reg;

    bom_validator u_validator (
        .clk               (CLK),
        .rstn              (RSTN),
        .rx_valid          (BOM_RX_VALID),
        .rx_match          (BOM_RX_MATCH),
        .rx_code           (BOM_RX_CODE),
        .esf               (ESF_FORMAT),
        .validation_select (ctrl_reg[t1dl_pkg::VALSEL_BIT]),
        .declare_o         (decl),
        .code_o            (decl_code)
    );

    // wishbone: ack one cycle after the strobe, writes land on the ack edge
    assign idx      = WB_ADR_I[9:2];
    assign ack_next = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign wr_take  = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg & WB_SEL_I[0];

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            if (ack_next) begin
                dat_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            t1dl_pkg::IDX_BOM_CTRL:  rd_byte = {6'h00, ctrl_reg};
            t1dl_pkg::IDX_BOM_EVENT: rd_byte = {7'h00, flag_reg};
            t1dl_pkg::IDX_BOM_CODE:  rd_byte = {2'h0, code_reg};
            t1dl_pkg::IDX_TX_EN:     rd_byte = {5'h00, txen_reg};
            t1dl_pkg::IDX_RX_EN:     rd_byte = {5'h00, rxen_reg};
            t1dl_pkg::IDX_TX2_MAP:   rd_byte = {1'b0, map_reg[0]};
            t1dl_pkg::IDX_TX3_MAP:   rd_byte = {1'b0, map_reg[1]};
            t1dl_pkg::IDX_RX2_MAP:   rd_byte = {1'b0, map_reg[2]};
            t1dl_pkg::IDX_RX3_MAP:   rd_byte = {1'b0, map_reg[3]};
            t1dl_pkg::IDX_TX2_MASK:  rd_byte = mask_reg[0];
            t1dl_pkg::IDX_TX3_MASK:  rd_byte = mask_reg[1];
            t1dl_pkg::IDX_RX2_MASK:  rd_byte = mask_reg[2];
            t1dl_pkg::IDX_RX3_MASK:  rd_byte = mask_reg[3];
            default:                 rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctrl_reg <= t1dl_pkg::RST_CTRL;
            txen_reg <= t1dl_pkg::RST_EN;
            rxen_reg <= t1dl_pkg::RST_EN;
        end else if (wr_take) begin
            if (idx == t1dl_pkg::IDX_BOM_CTRL) begin
                ctrl_reg <= WB_DAT_I[1:0];
            end
            if (idx == t1dl_pkg::IDX_TX_EN) begin
                txen_reg <= WB_DAT_I[2:0];
            end
            if (idx == t1dl_pkg::IDX_RX_EN) begin
                rxen_reg <= WB_DAT_I[2:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            for (int k = 0; k < t1dl_pkg::UNITS; k++) begin
                map_reg[k]  <= t1dl_pkg::RST_MAP;
                mask_reg[k] <= t1dl_pkg::RST_MASK;
            end
        end else if (wr_take) begin
            for (int k = 0; k < t1dl_pkg::UNITS; k++) begin
                if (idx == t1dl_pkg::MAP_IDX[k]) begin
                    map_reg[k] <= WB_DAT_I[6:0];
                end
                if (idx == t1dl_pkg::MASK_IDX[k]) begin
                    mask_reg[k] <= WB_DAT_I[7:0];
                end
            end
        end
    end

    // a new declaration in the clearing cycle keeps the flag set [RULE5]
    assign flag_clr  = wr_take & (idx == t1dl_pkg::IDX_BOM_EVENT)
                     & WB_DAT_I[t1dl_pkg::FLAG_BIT];
    assign flag_next = decl | (flag_reg & ~flag_clr);

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next; // [RULE5]
        end
    end

    // field bit 5 carries the message LSB, so the code is bit-reversed
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            code_reg <= t1dl_pkg::RST_CODE;
        end else if (decl) begin
            for (int i = 0; i < 6; i++) begin
                code_reg[i] <= decl_code[5-i]; // [RULE6]
            end
        end
    end

    assign MSG_IRQ = flag_reg & ctrl_reg[t1dl_pkg::IRQEN_BIT]; // [RULE4]

    // link 1 carries the data link only in ESF and DM [RULE8] [RULE10]
    assign fmt_dl = ESF_FORMAT | DM_FORMAT;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tx_en_reg <= t1dl_pkg::RST_EN;
            rx_en_reg <= t1dl_pkg::RST_EN;
        end else begin
            tx_en_reg <= {txen_reg[2:1], txen_reg[0] & fmt_dl}; // [RULE7] [RULE8]
            rx_en_reg <= {rxen_reg[2:1], rxen_reg[0] & fmt_dl}; // [RULE9] [RULE10]
        end
    end

    assign TX_LINK_EN = tx_en_reg;
    assign RX_LINK_EN = rx_en_reg;

    assign unit_en = {rxen_reg[t1dl_pkg::LINK3_BIT],
                      rxen_reg[t1dl_pkg::LINK2_BIT],
                      txen_reg[t1dl_pkg::LINK3_BIT],
                      txen_reg[t1dl_pkg::LINK2_BIT]};

    // index 0 is the first bit on the line, matched by lane select bit 7
    assign lane = t1dl_pkg::LAST_LANE - LINE_BIT_INDEX; // [RULE14] [RULE17]

    genvar g;
    generate
        for (g = 0; g < t1dl_pkg::UNITS; g++) begin : g_unit
            logic frame_ok;
            logic slot_ok;
            // with both frame selects clear nothing else is looked at
            assign frame_ok = LINE_FRAME_ODD ? map_reg[g][t1dl_pkg::ODD_BIT]
                                             : map_reg[g][t1dl_pkg::EVEN_BIT]; // [RULE11] [RULE15]
            assign slot_ok  = (map_reg[g][4:0] <= t1dl_pkg::LAST_SLOT)
                            & (map_reg[g][4:0] == LINE_CHANNEL); // [RULE12] [RULE16] [RULE18]
            assign hit[g]   = LINE_BIT_VALID & unit_en[g] & frame_ok
                            & slot_ok & mask_reg[g][lane]; // [RULE13] [RULE17]
        end
    endgenerate

    // sender 2 wins a lane claimed by both; software should not overlap them
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            tx_bit_reg   <= 1'b0;
            tx_val_reg   <= 1'b0;
            tx2_take_reg <= 1'b0;
            tx3_take_reg <= 1'b0;
        end else begin
            tx_val_reg   <= LINE_BIT_VALID;
            tx2_take_reg <= hit[0];
            tx3_take_reg <= hit[1] & ~hit[0];
            if (hit[0]) begin
                tx_bit_reg <= TX2_HDLC_BIT;
            end else if (hit[1]) begin
                tx_bit_reg <= TX3_HDLC_BIT;
            end else begin
                tx_bit_reg <= TX_LINE_BIT_I; // [RULE13]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rx2_val_reg <= 1'b0;
            rx3_val_reg <= 1'b0;
            rx_bit_reg  <= 1'b0;
        end else begin
            rx2_val_reg <= hit[2];
            rx3_val_reg <= hit[3];
            if (LINE_BIT_VALID) begin
                rx_bit_reg <= RX_LINE_BIT;
            end
        end
    end

    assign WB_ACK_O        = ack_reg;
    assign WB_DAT_O        = dat_reg;
    assign TX_LINE_BIT_O   = tx_bit_reg;
    assign TX_LINE_VALID_O = tx_val_reg;
    assign TX2_BIT_TAKEN   = tx2_take_reg;
    assign TX3_BIT_TAKEN   = tx3_take_reg;
    assign RX2_BIT_VALID   = rx2_val_reg;
    assign RX3_BIT_VALID   = rx3_val_reg;
    assign RX_HDLC_BIT     = rx_bit_reg;

    sequence s_flag_rise_enabled;
        !flag_reg ##1 flag_reg && ctrl_reg[t1dl_pkg::IRQEN_BIT];
    endsequence

    property p_irq_follows;
        @(posedge CLK) disable iff (!RSTN)
        s_flag_rise_enabled |-> MSG_IRQ;
    endproperty
    a_irq_follows: assert property (p_irq_follows) // [RULE4]
        else $error("interrupt missing for enabled message flag");

    property p_irq_masked;
        @(posedge CLK) disable iff (!RSTN)
        !ctrl_reg[t1dl_pkg::IRQEN_BIT] |-> !MSG_IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // [RULE4]
        else $error("interrupt raised while disabled");

    property p_flag_holds;
        @(posedge CLK) disable iff (!RSTN)
        flag_reg && !flag_clr |=> flag_reg;
    endproperty
    a_flag_holds: assert property (p_flag_holds) // [RULE5]
        else $error("message flag dropped without a clearing write");

    property p_code_loaded;
        @(posedge CLK) disable iff (!RSTN)
        decl |=> code_reg[5] == $past(decl_code[0])
              && code_reg[0] == $past(decl_code[5]) && flag_reg;
    endproperty
    a_code_loaded: assert property (p_code_loaded) // [RULE5] [RULE6]
        else $error("declared code not loaded reversed");

    property p_link1_format;
        @(posedge CLK) disable iff (!RSTN)
        !fmt_dl ##1 !fmt_dl |-> !TX_LINK_EN[0] && !RX_LINK_EN[0];
    endproperty
    a_link1_format: assert property (p_link1_format) // [RULE8] [RULE10]
        else $error("link 1 enabled outside ESF and DM");

    property p_tx_disabled;
        @(posedge CLK) disable iff (!RSTN)
        !txen_reg[t1dl_pkg::LINK2_BIT] |=> !TX2_BIT_TAKEN;
    endproperty
    a_tx_disabled: assert property (p_tx_disabled) // [RULE7]
        else $error("disabled sender 2 took a bit");

    property p_rx_disabled;
        @(posedge CLK) disable iff (!RSTN)
        !rxen_reg[t1dl_pkg::LINK3_BIT] |=> !RX3_BIT_VALID;
    endproperty
    a_rx_disabled: assert property (p_rx_disabled) // [RULE9]
        else $error("disabled receiver 3 extracted a bit");

    property p_slot_range;
        @(posedge CLK) disable iff (!RSTN)
        map_reg[0][4:0] > 5'h17 |=> !TX2_BIT_TAKEN;
    endproperty
    a_slot_range: assert property (p_slot_range) // [RULE18]
        else $error("out of range slot inserted data");

    property p_lane_select;
        @(posedge CLK) disable iff (!RSTN)
        TX2_BIT_TAKEN |-> $past(mask_reg[0][3'h7 - LINE_BIT_INDEX])
                       && $past(LINE_CHANNEL) == $past(map_reg[0][4:0])
                       && TX_LINE_BIT_O == $past(TX2_HDLC_BIT);
    endproperty
    a_lane_select: assert property (p_lane_select) // [RULE12] [RULE13] [RULE14]
        else $error("sender 2 bit placed at wrong lane");

    property p_frame_select;
        @(posedge CLK) disable iff (!RSTN)
        RX2_BIT_VALID |-> ($past(LINE_FRAME_ODD) ? $past(map_reg[2][5])
                                                 : $past(map_reg[2][6]))
                       && $past(LINE_CHANNEL) == $past(map_reg[2][4:0]);
    endproperty
    a_frame_select: assert property (p_frame_select) // [RULE15] [RULE16]
        else $error("receiver 2 extracted from unselected frame");

    property p_ack_pulse;
        @(posedge CLK) disable iff (!RSTN)
        WB_CYC_I && WB_STB_I && !ack_reg |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack not a single cycle after request");

endmodule : t1_data_link_control

// File: dv/line_src.sv
`timescale 1ns/10ps
module line_src (
    input  logic       clk,
    input  logic       rstn,
    input  logic       run,
    input  logic       slow,
    output logic       valid,
    output logic [4:0] chan,
    output logic [2:0] lane,
    output logic       odd,
    output logic       tx_bit,
    output logic       rx_bit
);
    logic [7:0] pat_reg;

    // data moves even when idle so a stale bit never passes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pat_reg <= 8'h00;
        end else begin
            pat_reg <= pat_reg + 8'h35;
        end
    end
    assign tx_bit = pat_reg[3];
    assign rx_bit = pat_reg[6];

    // slow mode leaves a gap after every bit position
    always_ff @(posedge clk) begin
        if (!rstn || !run) begin
            valid <= 1'b0;
            chan  <= 5'h00;
            lane  <= 3'h0;
            odd   <= 1'b0;
        end else begin
            valid <= !(slow && valid);
            if (valid) begin
                lane <= lane + 3'h1;
                if (lane == 3'h7) begin
                    chan <= (chan == 5'h17) ? 5'h00 : chan + 5'h01;
                    odd  <= (chan == 5'h17) ? ~odd : odd;
                end
            end
        end
    end
endmodule : line_src

// File: dv/t1_data_link_control_tb.sv
`timescale 1ns/10ps
module t1_data_link_control_tb;
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, esf = 1'b1, dm = 1'b0, bv = 1'b0, bm = 1'b0;
    logic        run = 1'b0, slow = 1'b0, pv = 1'b0, a2, a3;
    logic [9:0]  adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic [5:0]  bc = '0;
    logic [1:0]  hb = '0;
    logic [7:0]  ex = '0;
    logic [2:0]  txe = '0, rxe = '0, txen, rxen, li;
    logic [7:0]  mp [4] = '{default: 8'h00};
    logic [7:0]  mk [4] = '{default: 8'h00};
    logic [4:0]  lc;
    logic        ack, irq, lv, lo, txb, rxb, tlo, tlv, t2, t3, r2, r3, rhb;
    int          failures = 0, num_checks = 0, nv = 0;
    int          cnt [4] = '{default: 0};

    always #2 clk = ~clk;
    always @(posedge clk) hb <= hb + 2'h1;

    t1_data_link_control u_dut (
        .CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .ESF_FORMAT(esf), .DM_FORMAT(dm), .BOM_RX_VALID(bv),
        .BOM_RX_MATCH(bm), .BOM_RX_CODE(bc), .MSG_IRQ(irq),
        .TX_LINK_EN(txen), .RX_LINK_EN(rxen), .LINE_BIT_VALID(lv),
        .LINE_CHANNEL(lc), .LINE_BIT_INDEX(li), .LINE_FRAME_ODD(lo),
        .TX_LINE_BIT_I(txb), .TX2_HDLC_BIT(hb[0]),
        .TX3_HDLC_BIT(hb[1]), .RX_LINE_BIT(rxb), .TX_LINE_BIT_O(tlo),
        .TX_LINE_VALID_O(tlv), .TX2_BIT_TAKEN(t2), .TX3_BIT_TAKEN(t3),
        .RX2_BIT_VALID(r2), .RX3_BIT_VALID(r3), .RX_HDLC_BIT(rhb)
    );
    line_src u_line (
        .clk(clk), .rstn(rstn), .run(run), .slow(slow), .valid(lv),
        .chan(lc), .lane(li), .odd(lo), .tx_bit(txb), .rx_bit(rxb)
    );

    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [7:0] e, s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            failures++;
            summarize();
        end
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rd

    task automatic send(input logic [5:0] c, input int n, input logic m);
        repeat (n) begin
            bv <= 1'b1;
            bm <= m;
            bc <= c;
            @(posedge clk);
            bv <= 1'b0;
            bc <= ~c;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask : send

    function automatic logic [7:0] rev(input logic [5:0] c);
        return {2'b00, c[0], c[1], c[2], c[3], c[4], c[5]};
    endfunction : rev

    function automatic logic hit(input int u);
        return (lo ? mp[u][5] : mp[u][6]) && mp[u][4:0] == lc
               && mk[u][3'h7 - li];
    endfunction : hit

    // reference of every line bit, compared one cycle later
    always @(posedge clk) begin
        if (pv) begin
            nv++;
            cnt[0] += t2;
            cnt[1] += t3;
            cnt[2] += r2;
            cnt[3] += r3;
            chk("line", ex, {t2, t3, r2, r3, tlo, rhb, tlv, 1'b0});
        end
        a2 = txe[1] & hit(0);
        a3 = txe[2] & hit(1) & ~a2;
        ex <= {a2, a3, rxe[1] & hit(2), rxe[2] & hit(3),
               a2 ? hb[0] : (a3 ? hb[1] : txb), rxb, 2'b10};
        pv <= lv;
    end

    task automatic sweep(input logic s, input logic [7:0] e0, e1, e2, e3);
        nv = 0;
        cnt = '{default: 0};
        slow <= s;
        run <= 1'b1;
        for (int n = 0; n < 2000 && nv < 384; n++) @(posedge clk);
        run <= 1'b0;
        if (nv < 384) failures++;
        repeat (4) @(posedge clk);
        chk("tx2 hits", e0, cnt[0][7:0]);
        chk("tx3 hits", e1, cnt[1][7:0]);
        chk("rx2 hits", e2, cnt[2][7:0]);
        chk("rx3 hits", e3, cnt[3][7:0]);
    endtask : sweep

    task automatic reg_scn;
        rd(8'h83, 8'h3F);
        rd(8'h81, 8'h00);
        rd(8'h85, 8'h00);
        wr(8'h83, 8'h00);
        rd(8'h83, 8'h3F);
    endtask : reg_scn

    task automatic bom_scn;
        send(6'h0B, 7, 1'b1);
        rd(8'h82, 8'h00);
        send(6'h0B, 1, 1'b1);
        rd(8'h82, 8'h01);
        rd(8'h83, rev(6'h0B));
        chk("irq off", 8'h00, {7'h0, irq});
        wr(8'h81, 8'h01);
        chk("irq on", 8'h01, {7'h0, irq});
        wr(8'h82, 8'h01);
        chk("irq clr", 8'h00, {7'h0, irq});
        send(6'h0B, 1, 1'b1);
        rd(8'h82, 8'h00);
        wr(8'h81, 8'h03);
        send(6'h25, 4, 1'b0);
        rd(8'h82, 8'h00);
        send(6'h25, 4, 1'b1);
        rd(8'h82, 8'h01);
        rd(8'h83, rev(6'h25));
        wr(8'h82, 8'h01);
        esf <= 1'b0;
        send(6'h12, 4, 1'b1);
        rd(8'h82, 8'h00);
        send(6'h12, 4, 1'b1);
        rd(8'h82, 8'h01);
    endtask : bom_scn

    task automatic link_scn;
        wr(8'h84, 8'h07);
        wr(8'h8B, 8'h07);
        @(posedge clk);
        chk("tx en", 8'h06, {5'h0, txen});
        chk("rx en", 8'h06, {5'h0, rxen});
        dm <= 1'b1;
        repeat (2) @(posedge clk);
        chk("tx en", 8'h07, {5'h0, txen});
        chk("rx en", 8'h07, {5'h0, rxen});
        wr(8'h84, 8'h04);
        wr(8'h8B, 8'h02);
        @(posedge clk);
        chk("tx en", 8'h04, {5'h0, txen});
        chk("rx en", 8'h02, {5'h0, rxen});
    endtask : link_scn

    task automatic map_scn;
        mp = '{8'h57, 8'h20, 8'h78, 8'h65};
        mk = '{8'h80, 8'h01, 8'hFF, 8'h42};
        for (int i = 0; i < 4; i++) begin
            wr(t1dl_pkg::MAP_IDX[i], mp[i]);
            wr(t1dl_pkg::MASK_IDX[i], mk[i]);
        end
        rd(8'h86, 8'h57);
        rd(8'h91, 8'h42);
        txe = 3'h0;
        rxe = 3'h6;
        wr(8'h84, 8'h00);
        wr(8'h8B, 8'h06);
        sweep(1'b1, 8'h00, 8'h00, 8'h00, 8'h04);
        txe = 3'h6;
        rxe = 3'h0;
        wr(8'h84, 8'h06);
        wr(8'h8B, 8'h00);
        sweep(1'b0, 8'h01, 8'h01, 8'h00, 8'h00);
        mp[0] = 8'h17;
        wr(8'h86, 8'h17);
        sweep(1'b0, 8'h00, 8'h01, 8'h00, 8'h00);
    endtask : map_scn

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        reg_scn();
        bom_scn();
        link_scn();
        map_scn();
        summarize();
    end
endmodule : t1_data_link_control_tb
